/* cff_pkg.sv */
// Constants, field layout and carrier types of the comm/fuse fault status
// bank. Assumes one 100 MHz core clock and an AXI4-Lite register port.
//
// What this block does
// R1: A heartbeat that fails to arrive within the longest interval sets bit 1.
// R2: A heartbeat that comes sooner than the shortest interval sets bit 0.
// R3: The direction bit picks the low side port at 0, high side port at 1.
// R4: A fault tone seen too soon after the last heartbeat also sets bit 0.
// R5: Bit 2 marks a fault tone, bit 3 a stack fault report; bits 7-4 read 0.
// R6: An uncorrectable double bit error during fuse load sets fuse bit 6.
// R7: A corrected single bit error during fuse load sets fuse bit 5.
// R8: A check mismatch over the user fuse space sets fuse bit 4.
// R9: A check mismatch over the maker fuse space sets fuse bit 3.
// R10: Any of four user page faults found at load sets fuse bit 2.
// R11: The same four page faults on the maker pages set fuse bit 1.
// R12: The fuse data clear leaves both load error bits alone.
// R13: An overvoltage on any fuse page sets fuse bit 0.
// R14: Bit 0 clears only by reset; a new page program re-evaluates it.
// R15: The host distrusts data while a load or overvoltage bit is set.
// R16: The summary bit is 1 when an unmasked fuse fault is set, else 0.
package cff_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 12;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_COMM_HB = 12'h532;
  localparam logic [IDX_W-1:0] IDX_FUSE_LOAD = 12'h535;
  localparam logic [IDX_W-1:0] IDX_CTRL = 12'h540;
  localparam logic [IDX_W-1:0] IDX_COMM_CLR = 12'h541;
  localparam logic [IDX_W-1:0] IDX_FUSE_CLR = 12'h542;
  localparam logic [IDX_W-1:0] IDX_SUMMARY = 12'h543;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'h544;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 12'h545;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 12'h546;

  // Heartbeat register fields
  localparam int HB_QUICK_BIT = 0;
  localparam int HB_MISS_BIT = 1;
  localparam int TONE_BIT = 2;
  localparam int STACK_BIT = 3;
  localparam int COMM_W = 4;

  // Fuse register fields
  localparam int PAGE_OV_BIT = 0;
  localparam int MAKER_LD_BIT = 1;
  localparam int USER_LD_BIT = 2;
  localparam int MAKER_CRC_BIT = 3;
  localparam int USER_CRC_BIT = 4;
  localparam int SINGLE_BIT = 5;
  localparam int DOUBLE_BIT = 6;
  localparam int FUSE_W = 7;

  // Control register fields
  localparam int DIR_SEL_BIT = 0;
  localparam int FUSE_MASK_BIT = 1;
  localparam int FUSE_CLR_BIT = 0;

  // Interrupt layout: the four comm events, then any fuse fault event other than the two page load faults
  localparam int IRQ_FUSE_BIT = 4;
  localparam int IRQ_W = 5;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Heartbeat interval window, times in microseconds
  localparam int CLK_MHZ = 100;
  localparam int HB_MIN_US = 100;
  localparam int HB_MAX_US = 400;
  // Least time rounds up, longest time rounds down
  localparam int HB_MIN_CYC_DEF = (HB_MIN_US * CLK_MHZ * 1000 + 999) / 1000;
  localparam int HB_MAX_CYC_DEF = (HB_MAX_US * CLK_MHZ * 1000) / 1000;
  localparam int HB_CNT_W = 32;

  // Link events, one-cycle pulses
  typedef struct packed {
    logic hb_low;
    logic hb_high;
    logic tone_low;
    logic tone_high;
    logic stack_report;
  } cff_link_ev_t;

  // Page conditions of one fuse space, levels valid with the load strobe
  typedef struct packed {
    logic none_programmed;
    logic page_format_error;
    logic attempted_not_ok;
    logic page_load_error;
  } cff_page_cond_t;

  // Fuse load engine events
  typedef struct packed {
    logic load_done;
    logic double_err;
    logic single_err;
    logic user_crc_err;
    logic maker_crc_err;
    logic page_ov;
    logic reprogram_done;
    logic page_ov_present;
  } cff_fuse_ev_t;

  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_HAVE = 3'b010,
    WR_RESP = 3'b100
  } cff_wr_state_t;

endpackage

/* cff_fault_regs.sv */
// Comm heartbeat and fuse load fault status bank behind AXI4-Lite.
// Assumes link and fuse events are single-cycle pulses synchronous to aclk.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module cff_fault_regs
#(
  parameter int HB_MIN_CYC = cff_pkg::HB_MIN_CYC_DEF,
  parameter int HB_MAX_CYC = cff_pkg::HB_MAX_CYC_DEF
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cff_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cff_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cff_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [cff_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cff_pkg::cff_link_ev_t link_ev,
  input wire cff_pkg::cff_fuse_ev_t fuse_ev,
  input wire cff_pkg::cff_page_cond_t user_page,
  input wire cff_pkg::cff_page_cond_t maker_page,
  input wire logic hardware_reset_cmd,
  output logic fuse_fault_summary,
  output logic irq
);
  import cff_pkg::*;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(logic [IDX_W-1:0] idx);
    reg_addr = {{(ADDR_W-IDX_W-2){1'b0}}, idx, 2'b00};
  endfunction

  // Status state
  logic [COMM_W-1:0] comm_q;
  logic [FUSE_W-1:0] fuse_q;
  logic [3:0] ecc_crc_q;
  logic user_ld_q, maker_ld_q, page_ov_q;
  logic dir_sel_q, fuse_mask_q, hb_armed_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_en_q;
  logic [HB_CNT_W-1:0] hb_cnt_q;

  // Bus state
  cff_wr_state_t wr_state_q;
  logic aw_have_q, w_have_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // Write strobes decoded from the held write
  logic wr_fire, wr_lane0, wr_ctrl, wr_irq_en, fuse_data_clr, wr_hit;
  logic [COMM_W-1:0] comm_clr;
  logic [IRQ_W-1:0] irq_clr;

  // Heartbeat supervision signals
  logic sel_hb, sel_tone, hb_early, hb_quick_ev, hb_miss_ev, fault_wipe;
  logic [COMM_W-1:0] comm_set;
  logic [FUSE_W-1:0] fuse_set;

  // Device reset and the hardware reset command both wipe the fault bits
  assign fault_wipe = !aresetn || hardware_reset_cmd;

  // ---------------- AXI4-Lite write channel ----------------
  // Address and data may come in either order; both are held until the
  // response is taken, so only one write is ever in flight.
  assign s_axi_awready = (wr_state_q != WR_RESP) && !aw_have_q;
  assign s_axi_wready = (wr_state_q != WR_RESP) && !w_have_q;
  assign s_axi_bvalid = (wr_state_q == WR_RESP);
  assign s_axi_bresp = bresp_q;
  assign wr_fire = (wr_state_q == WR_HAVE);
  assign wr_lane0 = wr_fire && wstrb_q[0];

  // Capture address and data as their handshakes complete
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (wr_fire)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // Write sequencing: gather, perform for one cycle, respond
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_q <= WR_IDLE;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      case (wr_state_q)
        WR_IDLE:
          if (aw_have_q && w_have_q)
            wr_state_q <= WR_HAVE;
        WR_HAVE:
        begin
          bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          wr_state_q <= WR_RESP;
        end
        WR_RESP:
          if (s_axi_bready)
            wr_state_q <= WR_IDLE;
        default:
          wr_state_q <= WR_IDLE;
      endcase
    end
  end

  // Write decode; status registers are read only and answer with an error
  always_comb
  begin
    wr_hit = 1'b1;
    wr_ctrl = 1'b0;
    wr_irq_en = 1'b0;
    comm_clr = '0;
    fuse_data_clr = 1'b0;
    irq_clr = '0;
    if (awaddr_q == reg_addr(IDX_CTRL))
      wr_ctrl = wr_lane0;
    else if (awaddr_q == reg_addr(IDX_COMM_CLR))
      comm_clr = wr_lane0 ? wdata_q[COMM_W-1:0] : '0;
    else if (awaddr_q == reg_addr(IDX_FUSE_CLR))
      fuse_data_clr = wr_lane0 && wdata_q[FUSE_CLR_BIT];
    else if (awaddr_q == reg_addr(IDX_IRQ_EN))
      wr_irq_en = wr_lane0;
    else if (awaddr_q == reg_addr(IDX_IRQ_CLR))
      irq_clr = wr_lane0 ? wdata_q[IRQ_W-1:0] : '0;
    else
      wr_hit = 1'b0;
  end

  // Software control bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dir_sel_q <= 1'b0;
      fuse_mask_q <= 1'b0;
      irq_en_q <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        dir_sel_q <= wdata_q[DIR_SEL_BIT];
        fuse_mask_q <= wdata_q[FUSE_MASK_BIT];
      end
      if (wr_irq_en)
        irq_en_q <= wdata_q[IRQ_W-1:0];
    end
  end

  // ---------------- AXI4-Lite read channel ----------------
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Read data registered one cycle after the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      if (s_axi_araddr == reg_addr(IDX_COMM_HB))
        rdata_q[COMM_W-1:0] <= comm_q; // [R5]
      else if (s_axi_araddr == reg_addr(IDX_FUSE_LOAD))
        rdata_q[FUSE_W-1:0] <= fuse_q;
      else if (s_axi_araddr == reg_addr(IDX_CTRL))
        rdata_q[FUSE_MASK_BIT:DIR_SEL_BIT] <= {fuse_mask_q, dir_sel_q};
      else if (s_axi_araddr == reg_addr(IDX_SUMMARY))
        rdata_q[0] <= fuse_fault_summary;
      else if (s_axi_araddr == reg_addr(IDX_IRQ_STAT))
        rdata_q[IRQ_W-1:0] <= irq_stat_q;
      else if (s_axi_araddr == reg_addr(IDX_IRQ_EN))
        rdata_q[IRQ_W-1:0] <= irq_en_q;
      else if (s_axi_araddr != reg_addr(IDX_COMM_CLR) &&
               s_axi_araddr != reg_addr(IDX_FUSE_CLR) &&
               s_axi_araddr != reg_addr(IDX_IRQ_CLR))
        rresp_q <= RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // ---------------- Heartbeat supervision ----------------
  // Only the side picked by the direction bit is watched
  assign sel_hb = dir_sel_q ? link_ev.hb_high : link_ev.hb_low; // [R3]
  assign sel_tone = dir_sel_q ? link_ev.tone_high : link_ev.tone_low; // [R3]
  assign hb_early = hb_cnt_q < HB_CNT_W'(HB_MIN_CYC);
  // A tone close behind a heartbeat looks like a fast heartbeat
  assign hb_quick_ev = hb_armed_q && hb_early && (sel_hb || sel_tone); // [R2] [R4]
  assign hb_miss_ev = hb_armed_q && !sel_hb &&
                      (hb_cnt_q == HB_CNT_W'(HB_MAX_CYC - 1)); // [R1]

  // Interval counter; it saturates at the limit so a miss reports once.
  // Switching sides disarms until the new side delivers a heartbeat.
  always_ff @(posedge aclk)
  begin
    if (fault_wipe)
    begin
      hb_cnt_q <= '0;
      hb_armed_q <= 1'b0;
    end
    else if (wr_ctrl && (wdata_q[DIR_SEL_BIT] != dir_sel_q))
    begin
      hb_cnt_q <= '0;
      hb_armed_q <= 1'b0;
    end
    else if (sel_hb)
    begin
      hb_cnt_q <= '0;
      hb_armed_q <= 1'b1;
    end
    else if (hb_cnt_q < HB_CNT_W'(HB_MAX_CYC))
      hb_cnt_q <= hb_cnt_q + HB_CNT_W'(1);
  end

  // Comm fault flags; a new event beats a clear in the same cycle
  always_comb
  begin
    comm_set = '0;
    comm_set[HB_QUICK_BIT] = hb_quick_ev; // [R2]
    comm_set[HB_MISS_BIT] = hb_miss_ev; // [R1]
    comm_set[TONE_BIT] = sel_tone; // [R5]
    comm_set[STACK_BIT] = link_ev.stack_report; // [R5]
  end

  always_ff @(posedge aclk)
  begin
    if (fault_wipe)
      comm_q <= REG_RESET[COMM_W-1:0];
    else
      comm_q <= (comm_q & ~comm_clr) | comm_set;
  end

  // ---------------- Fuse load faults ----------------
  always_comb
  begin
    fuse_set = '0;
    fuse_set[DOUBLE_BIT] = fuse_ev.double_err; // [R6]
    fuse_set[SINGLE_BIT] = fuse_ev.single_err; // [R7]
    fuse_set[USER_CRC_BIT] = fuse_ev.user_crc_err; // [R8]
    fuse_set[MAKER_CRC_BIT] = fuse_ev.maker_crc_err; // [R9]
    fuse_set[PAGE_OV_BIT] = fuse_ev.page_ov; // [R13]
  end

  // Bits 6-3 follow events and the fuse data clear
  always_ff @(posedge aclk)
  begin
    if (fault_wipe)
      ecc_crc_q <= REG_RESET[3:0];
    else
      ecc_crc_q <= (ecc_crc_q & {4{!fuse_data_clr}}) |
        fuse_set[DOUBLE_BIT:MAKER_CRC_BIT];
  end

  // Field order matches the fuse bit constants, bit 6 down to bit 0
  assign fuse_q = {ecc_crc_q, user_ld_q, maker_ld_q, page_ov_q};

  // Load error bits are judged once per load; the data clear is not
  // looked at here, so only a new load or a reset changes them.
  always_ff @(posedge aclk)
  begin
    if (fault_wipe)
    begin
      user_ld_q <= 1'b0;
      maker_ld_q <= 1'b0;
    end
    else if (fuse_ev.load_done)
    begin
      user_ld_q <= |user_page; // [R10] [R12]
      maker_ld_q <= |maker_page; // [R11] [R12]
    end
  end

  // Page overvoltage: sticky until reset, re-judged after a new program
  always_ff @(posedge aclk)
  begin
    if (fault_wipe)
      page_ov_q <= 1'b0; // [R14]
    else if (fuse_ev.page_ov)
      page_ov_q <= 1'b1; // [R13]
    else if (fuse_ev.reprogram_done)
      page_ov_q <= fuse_ev.page_ov_present; // [R14]
  end

  // Summary is held in a flop so the output is glitch free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fuse_fault_summary <= 1'b0;
    else
      fuse_fault_summary <= !fuse_mask_q && (|fuse_q); // [R16]
  end

  // ---------------- Interrupts ----------------
  // Sticky on events; a set in the clear cycle survives
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) |
                    {|fuse_set, comm_set};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_en_q);
  end

endmodule

`default_nettype wire

/* cff_chain_model.sv */
// Model of the neighbouring stacked devices on the daisy chain.
// Assumes the bench drives its controls by non-blocking assignment.
`timescale 1ns/1ns
`default_nettype none

module cff_chain_model
(
  input wire logic aclk,
  input wire logic hb_en,
  input wire logic hb_side,
  input wire logic [7:0] hb_gap,
  input wire logic tone_req,
  input wire logic stack_req,
  output var cff_pkg::cff_link_ev_t link_ev
);
  import cff_pkg::*;
  logic [7:0] gap_q = 8'h00;
  cff_link_ev_t ev_q = '0;
  logic beat;

  // Heartbeat period; a stopped chain sends no heartbeats
  assign beat = hb_en && (gap_q == hb_gap - 8'h01);
  always_ff @(posedge aclk)
  begin
    gap_q <= beat || !hb_en ? 8'h00 : gap_q + 8'h01;
  end

  // One-cycle pulses, launched on the side the bench picks
  always_ff @(posedge aclk)
  begin
    ev_q.hb_low <= beat && !hb_side;
    ev_q.hb_high <= beat && hb_side;
    ev_q.tone_low <= tone_req && !hb_side;
    ev_q.tone_high <= tone_req && hb_side;
    ev_q.stack_report <= stack_req;
  end
  assign link_ev = ev_q;
endmodule
`default_nettype wire

/* cff_regs_monitor.sv */
// Concurrent checks on the fault status bank's ports.
// Assumes it is bound into cff_fault_regs and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module cff_regs_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cff_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [cff_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cff_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [cff_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cff_pkg::cff_fuse_ev_t fuse_ev,
  input wire logic hardware_reset_cmd,
  input wire logic fuse_fault_summary,
  input wire logic irq
);
  import cff_pkg::*;
  logic [15:0] ra_q;
  logic mask_q;
  logic wr_go;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address of the read in flight, to know what rdata means
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ra_q <= 16'h0000;
    else if (s_axi_arvalid && s_axi_arready)
      ra_q <= s_axi_araddr;
  end

  // Shadow of the fuse mask; only paired address/data writes are seen
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_q <= 1'b0;
    else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == {2'b00, IDX_CTRL, 2'b00})
      mask_q <= s_axi_wdata[FUSE_MASK_BIT];
  end

  sequence seq_hw_quiet;
    hardware_reset_cmd && fuse_ev == '0 ##1 fuse_ev == '0;
  endsequence
  sequence seq_resp_late;
    !s_axi_bvalid ##[1:2] s_axi_bvalid;
  endsequence

  comm_rsvd_a: assert property (s_axi_rvalid &&
    ra_q == {2'b00, IDX_COMM_HB, 2'b00} |-> s_axi_rdata[31:4] == 28'h0)
    else $error("comm register upper bits not zero");
  fuse_rsvd_a: assert property (s_axi_rvalid &&
    ra_q == {2'b00, IDX_FUSE_LOAD, 2'b00} |-> s_axi_rdata[31:7] == 25'h0)
    else $error("fuse register upper bits not zero");
  ov_summary_a: assert property (fuse_ev.page_ov && !mask_q
    |-> ##2 fuse_fault_summary)
    else $error("page overvoltage did not raise summary");
  hw_clear_a: assert property (seq_hw_quiet |=> !fuse_fault_summary)
    else $error("summary survived hardware reset");
  bresp_time_a: assert property (wr_go |=> seq_resp_late)
    else $error("write response not on time");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && !s_axi_arready)
    else $error("read data dropped early");
  reset_idle_a: assert property (disable iff (1'b0) !aresetn
    |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !fuse_fault_summary)
    else $error("outputs not idle after reset");
endmodule

bind cff_fault_regs cff_regs_monitor u_mon (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .fuse_ev, .hardware_reset_cmd, .fuse_fault_summary, .irq);
`default_nettype wire

/* comm_fuse_fault_status_tb_top.sv */
// Self-checking bench for the comm/fuse fault status bank.
// Assumes the chain model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none

module comm_fuse_fault_status_tb_top;
  import cff_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, hw_rst, summary, irq;
  logic hb_en, hb_side, tone_req, stack_req;
  logic [7:0] hb_gap;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  cff_link_ev_t link_ev;
  cff_fuse_ev_t fuse_ev;
  cff_page_cond_t user_page, maker_page;
  int bad_count, check_count;

  // Short heartbeat window keeps the run brief
  cff_fault_regs #(.HB_MIN_CYC(4), .HB_MAX_CYC(20)) uut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_ev(link_ev),
    .fuse_ev(fuse_ev), .user_page(user_page), .maker_page(maker_page),
    .hardware_reset_cmd(hw_rst), .fuse_fault_summary(summary), .irq(irq));

  cff_chain_model chain (.aclk(aclk), .hb_en(hb_en), .hb_side(hb_side),
    .hb_gap(hb_gap), .tone_req(tone_req), .stack_req(stack_req),
    .link_ev(link_ev));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic tally_and_finish;
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Register write; address and data offered together, response awaited
  task automatic wr(input logic [11:0] i, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] i, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge aclk);
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask

  // Fuse engine pulse, then time for flags and summary to settle
  task automatic pulse_f(input cff_fuse_ev_t v);
    @(posedge aclk);
    fuse_ev <= v;
    @(posedge aclk);
    fuse_ev <= '0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic hw_pulse;
    @(posedge aclk);
    hw_rst <= 1'b1;
    @(posedge aclk);
    hw_rst <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic beats(input logic side, input logic [7:0] gap);
    hb_side <= side;
    hb_gap <= gap;
    hb_en <= 1'b1;
    repeat (30) @(posedge aclk);
    hb_en <= 1'b0;
    repeat (40) @(posedge aclk);
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    tally_and_finish;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, hw_rst} = '0;
    {hb_en, hb_side, tone_req, stack_req, hb_gap} = '0;
    {awaddr, araddr, wdata, fuse_ev, user_page, maker_page} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_COMM_HB, 32'h0, RESP_OKAY);
    rd(IDX_FUSE_LOAD, 32'h0, RESP_OKAY);
    rd(12'h7ff, 32'h0, RESP_SLVERR);
    rd(IDX_COMM_CLR, 32'h0, RESP_OKAY);
    wr(IDX_FUSE_LOAD, 32'hff, RESP_SLVERR);
    rd(IDX_FUSE_LOAD, 32'h0, RESP_OKAY);
    // Steady low side beats, then silence
    beats(1'b0, 8'h08);
    rd(IDX_COMM_HB, 32'h2, RESP_OKAY);
    hw_pulse;
    rd(IDX_COMM_HB, 32'h0, RESP_OKAY);
    // High side watched: fast low side traffic must be ignored
    wr(IDX_CTRL, 32'h1, RESP_OKAY);
    beats(1'b0, 8'h02);
    rd(IDX_COMM_HB, 32'h0, RESP_OKAY);
    beats(1'b1, 8'h02);
    rd(IDX_COMM_HB, 32'h3, RESP_OKAY);
    hw_pulse;
    // Legal beat rate, but a tone right after a beat
    hb_side <= 1'b1;
    hb_gap <= 8'h08;
    hb_en <= 1'b1;
    repeat (20) @(posedge aclk);
    while (!link_ev.hb_high) @(posedge aclk);
    tone_req <= 1'b1;
    stack_req <= 1'b1;
    @(posedge aclk);
    {tone_req, stack_req, hb_en} <= 3'b000;
    repeat (40) @(posedge aclk);
    rd(IDX_COMM_HB, 32'hf, RESP_OKAY);
    // Each page condition on both spaces, then a load with a user space fault only
    for (int k = 0; k < 4; k++)
    begin
      user_page <= 4'h1 << k;
      maker_page <= 4'h1 << k;
      pulse_f(8'h80);
      rd(IDX_FUSE_LOAD, 32'h6, RESP_OKAY);
    end
    user_page <= 4'h8;
    maker_page <= 4'h0;
    pulse_f(8'h80);
    rd(IDX_FUSE_LOAD, 32'h4, RESP_OKAY);
    pulse_f(8'h7c);
    rd(IDX_FUSE_LOAD, 32'h7d, RESP_OKAY);
    chk({31'h0, summary}, 32'h1);
    wr(IDX_FUSE_CLR, 32'h1, RESP_OKAY);
    rd(IDX_FUSE_LOAD, 32'h5, RESP_OKAY);
    wr(IDX_CTRL, 32'h2, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, summary}, 32'h0);
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, summary}, 32'h1);
    pulse_f(8'h02);
    rd(IDX_FUSE_LOAD, 32'h4, RESP_OKAY);
    pulse_f(8'h03);
    rd(IDX_FUSE_LOAD, 32'h5, RESP_OKAY);
    hw_pulse;
    rd(IDX_FUSE_LOAD, 32'h0, RESP_OKAY);
    // Interrupt: raise, mask, unmask, clear
    wr(IDX_IRQ_CLR, 32'h1f, RESP_OKAY);
    wr(IDX_IRQ_EN, 32'h10, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    pulse_f(8'h40);
    chk({31'h0, irq}, 32'h1);
    rd(IDX_IRQ_STAT, 32'h10, RESP_OKAY);
    wr(IDX_IRQ_EN, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_EN, 32'h10, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_CLR, 32'h10, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(IDX_IRQ_EN, 32'h10, RESP_OKAY);
    tally_and_finish;
  end
endmodule
`default_nettype wire
